// ---- hw/slmfc_pkg.sv ----
`default_nettype none
package slmfc_pkg;

  // ****************************************************************
  // Datapath and register bus widths
  // ****************************************************************
  localparam int unsigned SLMFC_DATA_W     = 32;
  localparam int unsigned SLMFC_ADR_W      = 8;
  localparam int unsigned SLMFC_SEL_W      = 4;
  localparam int unsigned SLMFC_DLY_W      = 4;
  localparam int unsigned SLMFC_DLY_TAPS   = 16;
  localparam int unsigned SLMFC_LMFC_W     = 8;
  localparam int unsigned SLMFC_DEPTH_W    = 10;
  localparam int unsigned SLMFC_EVCNT_W    = 8;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [SLMFC_ADR_W-1:0] SLMFC_OFS_CTRL   = 8'h00;
  localparam logic [SLMFC_ADR_W-1:0] SLMFC_OFS_MFLEN  = 8'h04;
  localparam logic [SLMFC_ADR_W-1:0] SLMFC_OFS_DEPTH  = 8'h08;
  localparam logic [SLMFC_ADR_W-1:0] SLMFC_OFS_STATUS = 8'h0C;
  localparam logic [SLMFC_ADR_W-1:0] SLMFC_OFS_LMFC   = 8'h10;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int unsigned SLMFC_CTRL_PERIODIC = 0;
  localparam int unsigned SLMFC_CTRL_RESYNC   = 1;
  localparam int unsigned SLMFC_CTRL_DLY_LO   = 4;
  localparam int unsigned SLMFC_CTRL_SC2      = 8;
  localparam int unsigned SLMFC_CTRL_LSYNC    = 9;
  localparam int unsigned SLMFC_CTRL_BRAM     = 10;
  localparam logic [SLMFC_DATA_W-1:0] SLMFC_CTRL_RST  = 32'h0000_0200;
  localparam logic [SLMFC_DATA_W-1:0] SLMFC_CTRL_MASK = 32'h0000_07F3;

  // ****************************************************************
  // Other register reset values and status fields
  // ****************************************************************
  localparam logic [SLMFC_LMFC_W-1:0]  SLMFC_MFLEN_RST = 8'h07;
  localparam logic [SLMFC_DEPTH_W-1:0] SLMFC_DEPTH_RST = 10'h020;
  localparam int unsigned SLMFC_ST_VALID    = 0;
  localparam int unsigned SLMFC_ST_RXLINK   = 1;
  localparam int unsigned SLMFC_ST_TXRUN    = 2;
  localparam int unsigned SLMFC_ST_RELEASED = 3;
  localparam int unsigned SLMFC_ST_ARMED    = 4;
  localparam int unsigned SLMFC_ST_EVCNT_LO = 8;

  // ****************************************************************
  // State encodings
  // ****************************************************************
  typedef enum logic [3:0] {
    SLMFC_RX_WAIT_REF = 4'h1,
    SLMFC_RX_WAIT_CGS = 4'h2,
    SLMFC_RX_WAIT_BND = 4'h4,
    SLMFC_RX_LINKED   = 4'h8
  } slmfc_rx_state_e;

  typedef enum logic [3:0] {
    SLMFC_TX_WAIT_REF  = 4'h1,
    SLMFC_TX_WAIT_SYNC = 4'h2,
    SLMFC_TX_WAIT_BND  = 4'h4,
    SLMFC_TX_RUN       = 4'h8
  } slmfc_tx_state_e;

endpackage
`default_nettype wire

// ---- hw/slmfc_ref_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface slmfc_ref_if;
  import slmfc_pkg::*;
  logic [SLMFC_DLY_W-1:0] ref_delay;
  logic                   ref_event;
  modport cap  (input ref_delay, output ref_event);
  modport core (output ref_delay, input ref_event);
endinterface
`default_nettype wire

// ---- hw/slmfc_sysref_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module slmfc_sysref_capture #(
  parameter bit P_SAMPLE_RISING = 1'b0
) (
  input  wire logic   i_mclk,
  input  wire logic   i_resetn,
  input  wire logic   i_sysref,
  slmfc_ref_if.cap    ref_bus
);
  import slmfc_pkg::*;

  logic                      first_q;
  logic                      second_q;
  logic                      third_q;
  logic                      detect;
  logic [SLMFC_DLY_TAPS-1:0] hist;
  logic                      delayed;

  // ****************************************************************
  // First sampling flop, edge fixed when the design is built
  // ****************************************************************
  generate
    if (P_SAMPLE_RISING) begin : g_rise
      always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) first_q <= 1'b0;
        else first_q <= i_sysref;
      end
    end else begin : g_fall
      // Falling edge gives margin when the source is edge-aligned to the clock
      always_ff @(negedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) first_q <= 1'b0;
        else first_q <= i_sysref;
      end
    end
  endgenerate

  // ****************************************************************
  // Rising-edge processing: edge detect and delay line
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      second_q <= 1'b0;
      third_q  <= 1'b0;
    end else begin
      second_q <= first_q;
      third_q  <= second_q;
    end
  end

  assign detect = second_q & ~third_q;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) hist[0] <= 1'b0;
    else hist[0] <= detect;
  end

  genvar gi;
  generate
    for (gi = 1; gi < SLMFC_DLY_TAPS; gi++) begin : g_dly
      always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) hist[gi] <= 1'b0;
        else hist[gi] <= hist[gi-1];
      end
    end
  endgenerate

  // Tap 0 is the undelayed event; tap N is N cycles late
  assign delayed = (ref_bus.ref_delay == '0) ? detect : hist[ref_bus.ref_delay - 4'h1];
  assign ref_bus.ref_event = delayed;

endmodule
`default_nettype wire

// ---- hw/slmfc_top.sv ----
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module slmfc_top #(
  parameter bit P_SAMPLE_RISING = 1'b0
) (
  input  wire logic                                i_mclk,
  input  wire logic                                i_resetn,
  input  wire logic                                i_sysref,
  input  wire logic                                i_wb_cyc,
  input  wire logic                                i_wb_stb,
  input  wire logic                                i_wb_we,
  input  wire logic [slmfc_pkg::SLMFC_ADR_W-1:0]   i_wb_adr,
  input  wire logic [slmfc_pkg::SLMFC_SEL_W-1:0]   i_wb_sel,
  input  wire logic [slmfc_pkg::SLMFC_DATA_W-1:0]  i_wb_dat,
  output logic [slmfc_pkg::SLMFC_DATA_W-1:0]       o_wb_dat,
  output logic                                     o_wb_ack,
  input  wire logic                                i_rx_cgs_done,
  input  wire logic                                i_rx_resync,
  input  wire logic                                i_rx_valid,
  input  wire logic [slmfc_pkg::SLMFC_DATA_W-1:0]  i_rx_data,
  output logic                                     o_rx_sync_n,
  output logic                                     o_rx_valid,
  output logic [slmfc_pkg::SLMFC_DATA_W-1:0]       o_rx_data,
  input  wire logic                                i_tx_sync_n,
  output logic                                     o_tx_ila_start,
  output logic                                     o_tx_data_start,
  output logic                                     o_tx_running,
  output logic                                     o_lmfc_pulse,
  output logic                                     o_buffer_in_block_memory,
  output logic [slmfc_pkg::SLMFC_DEPTH_W-1:0]      o_buffer_octet_depth
);
  import slmfc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  slmfc_ref_if ref_bus ();

  logic [SLMFC_DATA_W-1:0]  ctrl;
  logic [SLMFC_LMFC_W-1:0]  mf_last;
  logic [SLMFC_DEPTH_W-1:0] depth;
  logic [SLMFC_LMFC_W-1:0]  lmfc_cnt;
  logic [SLMFC_EVCNT_W-1:0] ev_cnt;
  logic                     armed;
  logic                     lmfc_valid;
  logic                     released;
  logic                     tx_sync_q;
  slmfc_rx_state_e          rx_state;
  slmfc_rx_state_e          next_rx_state;
  slmfc_tx_state_e          tx_state;
  slmfc_tx_state_e          next_tx_state;

  logic                     periodic_realign_enable;
  logic                     resync_needs_ref_event;
  logic                     subclass2;
  logic                     link_sync_enable;
  logic                     wb_req;
  logic                     wb_wr;
  logic [SLMFC_DATA_W-1:0]  rd_mux;
  logic [SLMFC_DATA_W-1:0]  status;
  logic                     accept;
  logic                     lmfc_bnd;
  logic                     lmfc_ok;
  logic                     tx_resync;
  logic                     resync;
  logic                     tx_start;

  // Byte-lane merge of a write into an existing register value
  function automatic logic [SLMFC_DATA_W-1:0] slmfc_merge(
    input logic [SLMFC_DATA_W-1:0] old_v,
    input logic [SLMFC_DATA_W-1:0] new_v,
    input logic [SLMFC_SEL_W-1:0]  sel
  );
    logic [SLMFC_DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < SLMFC_SEL_W; b++) begin
      if (sel[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic slmfc_hit(
    input logic [SLMFC_ADR_W-1:0] adr,
    input logic [SLMFC_ADR_W-1:0] ofs
  );
    return adr == ofs;
  endfunction

  // ****************************************************************
  // Reference capture
  // ****************************************************************
  slmfc_sysref_capture #(
    .P_SAMPLE_RISING (P_SAMPLE_RISING)
  ) u_cap (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_sysref (i_sysref),
    .ref_bus  (ref_bus.cap)
  );

  // A changed delay also retimes events still in the delay line; a core reset realigns the link
  assign ref_bus.ref_delay = ctrl[SLMFC_CTRL_DLY_LO +: SLMFC_DLY_W];

  // ****************************************************************
  // Register bus
  // ****************************************************************
  assign periodic_realign_enable = ctrl[SLMFC_CTRL_PERIODIC];
  assign resync_needs_ref_event  = ctrl[SLMFC_CTRL_RESYNC];
  assign subclass2               = ctrl[SLMFC_CTRL_SC2];
  assign link_sync_enable        = ctrl[SLMFC_CTRL_LSYNC];
  assign wb_req                  = i_wb_cyc & i_wb_stb;
  // Write lands on the edge where the master sees ack
  assign wb_wr                   = wb_req & i_wb_we & o_wb_ack;

  assign status = {16'h0000, ev_cnt, 3'b000, armed, released,
                   (tx_state == SLMFC_TX_RUN), (rx_state == SLMFC_RX_LINKED), lmfc_valid};

  assign rd_mux = slmfc_hit(i_wb_adr, SLMFC_OFS_CTRL)   ? ctrl :
                  slmfc_hit(i_wb_adr, SLMFC_OFS_MFLEN)  ? {24'h000000, mf_last} :
                  slmfc_hit(i_wb_adr, SLMFC_OFS_DEPTH)  ? {22'h000000, depth} :
                  slmfc_hit(i_wb_adr, SLMFC_OFS_STATUS) ? status :
                  slmfc_hit(i_wb_adr, SLMFC_OFS_LMFC)   ? {24'h000000, lmfc_cnt} :
                  32'h0000_0000;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req & ~o_wb_ack;
      o_wb_dat <= rd_mux;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl    <= SLMFC_CTRL_RST;
      mf_last <= SLMFC_MFLEN_RST;
      depth   <= SLMFC_DEPTH_RST;
    end else if (wb_wr) begin
      if (slmfc_hit(i_wb_adr, SLMFC_OFS_CTRL))
        ctrl <= slmfc_merge(ctrl, i_wb_dat, i_wb_sel) & SLMFC_CTRL_MASK;
      if (slmfc_hit(i_wb_adr, SLMFC_OFS_MFLEN))
        mf_last <= SLMFC_LMFC_W'(slmfc_merge({24'h000000, mf_last}, i_wb_dat, i_wb_sel));
      if (slmfc_hit(i_wb_adr, SLMFC_OFS_DEPTH))
        depth <= SLMFC_DEPTH_W'(slmfc_merge({22'h000000, depth}, i_wb_dat, i_wb_sel));
    end
  end

  // Buffer memory itself lives downstream; only its configuration is held here
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_buffer_in_block_memory <= 1'b0;
      o_buffer_octet_depth     <= SLMFC_DEPTH_RST;
    end else begin
      o_buffer_in_block_memory <= ctrl[SLMFC_CTRL_BRAM];
      o_buffer_octet_depth     <= depth;
    end
  end

  // ****************************************************************
  // LMFC counter and alignment
  // ****************************************************************
  // Subclass 2 ignores the reference and lets the counter free-run
  assign accept    = ref_bus.ref_event & ~subclass2 & (armed | periodic_realign_enable);
  assign lmfc_bnd  = (lmfc_cnt == mf_last);
  assign lmfc_ok   = lmfc_valid | subclass2;
  assign tx_resync = tx_sync_q & ~i_tx_sync_n & (tx_state == SLMFC_TX_RUN);
  assign resync    = i_rx_resync | tx_resync;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      lmfc_cnt <= 8'h00;
    end else if (accept || lmfc_bnd) begin
      lmfc_cnt <= 8'h00;
    end else begin
      lmfc_cnt <= lmfc_cnt + 8'h01;
    end
  end

  // Set wins over clear when an event meets a resync in one cycle
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      armed      <= 1'b1;
      lmfc_valid <= 1'b0;
    end else begin
      if (resync) armed <= 1'b1;
      else if (accept) armed <= 1'b0;
      if (accept) lmfc_valid <= 1'b1;
      else if (resync && resync_needs_ref_event) lmfc_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_cnt       <= 8'h00;
      o_lmfc_pulse <= 1'b0;
      tx_sync_q    <= 1'b0;
    end else begin
      if (accept) ev_cnt <= ev_cnt + 8'h01;
      o_lmfc_pulse <= lmfc_bnd;
      tx_sync_q    <= i_tx_sync_n;
    end
  end

  // ****************************************************************
  // Receive sync control
  // ****************************************************************
  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      SLMFC_RX_WAIT_REF: begin
        if (lmfc_ok) next_rx_state = SLMFC_RX_WAIT_CGS;
      end
      SLMFC_RX_WAIT_CGS: begin
        if (i_rx_cgs_done)
          next_rx_state = subclass2 ? SLMFC_RX_LINKED : SLMFC_RX_WAIT_BND;
      end
      SLMFC_RX_WAIT_BND: begin
        if (lmfc_bnd) next_rx_state = SLMFC_RX_LINKED;
      end
      SLMFC_RX_LINKED: begin
        next_rx_state = SLMFC_RX_LINKED;
      end
      default: next_rx_state = SLMFC_RX_WAIT_REF;
    endcase
    if (i_rx_resync) next_rx_state = SLMFC_RX_WAIT_REF;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_state    <= SLMFC_RX_WAIT_REF;
      o_rx_sync_n <= 1'b0;
    end else begin
      rx_state    <= next_rx_state;
      o_rx_sync_n <= (next_rx_state == SLMFC_RX_LINKED);
    end
  end

  // Data is held back until the first local crossing after all lanes are valid
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      released   <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data  <= 32'h0000_0000;
    end else begin
      if (rx_state != SLMFC_RX_LINKED || i_rx_resync) released <= 1'b0;
      else if (i_rx_valid && lmfc_bnd) released <= 1'b1;
      o_rx_valid <= released & i_rx_valid & (rx_state == SLMFC_RX_LINKED);
      o_rx_data  <= i_rx_data;
    end
  end

  // ****************************************************************
  // Transmit start control
  // ****************************************************************
  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      SLMFC_TX_WAIT_REF: begin
        if (lmfc_ok) next_tx_state = SLMFC_TX_WAIT_SYNC;
      end
      SLMFC_TX_WAIT_SYNC: begin
        if (i_tx_sync_n) next_tx_state = SLMFC_TX_WAIT_BND;
      end
      SLMFC_TX_WAIT_BND: begin
        if (!i_tx_sync_n) next_tx_state = SLMFC_TX_WAIT_SYNC;
        else if (lmfc_bnd) next_tx_state = SLMFC_TX_RUN;
      end
      SLMFC_TX_RUN: begin
        if (!i_tx_sync_n) next_tx_state = SLMFC_TX_WAIT_REF;
      end
      default: next_tx_state = SLMFC_TX_WAIT_REF;
    endcase
  end

  assign tx_start = (tx_state == SLMFC_TX_WAIT_BND) & (next_tx_state == SLMFC_TX_RUN);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_state        <= SLMFC_TX_WAIT_REF;
      o_tx_ila_start  <= 1'b0;
      o_tx_data_start <= 1'b0;
      o_tx_running    <= 1'b0;
    end else begin
      tx_state        <= next_tx_state;
      o_tx_ila_start  <= tx_start & link_sync_enable;
      o_tx_data_start <= tx_start & ~link_sync_enable;
      o_tx_running    <= (next_tx_state == SLMFC_TX_RUN);
    end
  end

endmodule
`default_nettype wire

// ---- test/slmfc_conv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module slmfc_conv_model (
  input  wire logic                               i_mclk,
  input  wire logic                               i_resetn,
  input  wire logic                               i_ref_go,
  input  wire logic                               i_sync_rel,
  input  wire logic                               i_cgs,
  input  wire logic                               i_data_on,
  output logic                                    o_sysref,
  output logic                                    o_tx_sync_n,
  output logic                                    o_cgs_done,
  output logic                                    o_rx_valid,
  output logic [slmfc_pkg::SLMFC_DATA_W-1:0]      o_rx_data
);
  import slmfc_pkg::*;
  logic [2:0] ref_cnt;
  // Only one-shot references are sent, so no period has to fit the multiframe
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ref_cnt     <= 3'h0;
      o_sysref    <= 1'b0;
      o_tx_sync_n <= 1'b0;
      o_cgs_done  <= 1'b0;
      o_rx_valid  <= 1'b0;
      o_rx_data   <= 32'h0000_0000;
    end else begin
      ref_cnt     <= i_ref_go ? 3'h4 : ref_cnt - {2'h0, ref_cnt != 3'h0};
      o_sysref    <= i_ref_go || ref_cnt > 3'h1;
      o_tx_sync_n <= i_sync_rel;
      o_cgs_done  <= i_cgs;
      o_rx_valid  <= i_data_on;
      // Words change every cycle, so a stale word never looks fresh
      o_rx_data   <= o_rx_data + 32'h0404_0404;
    end
  end
endmodule
`default_nettype wire

// ---- test/slmfc_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module slmfc_top_asserts (
  input  wire logic                               i_mclk,
  input  wire logic                               i_resetn,
  input  wire logic                               i_sysref,
  input  wire logic                               i_wb_cyc,
  input  wire logic                               i_wb_stb,
  input  wire logic                               i_wb_we,
  input  wire logic [slmfc_pkg::SLMFC_ADR_W-1:0]  i_wb_adr,
  input  wire logic [slmfc_pkg::SLMFC_SEL_W-1:0]  i_wb_sel,
  input  wire logic [slmfc_pkg::SLMFC_DATA_W-1:0] i_wb_dat,
  input  wire logic                               o_wb_ack,
  input  wire logic                               i_rx_cgs_done,
  input  wire logic                               i_rx_resync,
  input  wire logic [slmfc_pkg::SLMFC_DATA_W-1:0] i_rx_data,
  input  wire logic                               o_rx_sync_n,
  input  wire logic                               o_rx_valid,
  input  wire logic [slmfc_pkg::SLMFC_DATA_W-1:0] o_rx_data,
  input  wire logic                               i_tx_sync_n,
  input  wire logic                               o_tx_ila_start,
  input  wire logic                               o_tx_data_start,
  input  wire logic                               o_tx_running,
  input  wire logic                               o_lmfc_pulse
);
  import slmfc_pkg::*;
  // ****************************************************************
  // Shadow of the control fields the properties depend on
  // ****************************************************************
  logic [1:0] ctl_sh;
  logic [7:0] mflen_sh;
  logic [7:0] gap;
  logic [6:0] quiet;
  wire        wr_ack  = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
  wire        ctrl_wr = wr_ack && i_wb_adr == SLMFC_OFS_CTRL && i_wb_sel[1];
  wire        mf_wr   = wr_ack && i_wb_adr == SLMFC_OFS_MFLEN && i_wb_sel[0];
  always_ff @(posedge i_mclk or negedge i_resetn)
    if (!i_resetn) ctl_sh <= 2'h2;
    else if (ctrl_wr) ctl_sh <= i_wb_dat[9:8];
  always_ff @(posedge i_mclk or negedge i_resetn)
    if (!i_resetn) mflen_sh <= 8'h07;
    else if (mf_wr) mflen_sh <= i_wb_dat[7:0];
  always_ff @(posedge i_mclk or negedge i_resetn)
    if (!i_resetn) gap <= 8'h00;
    else if (o_lmfc_pulse) gap <= 8'h00;
    else if (gap != 8'hFF) gap <= gap + 8'h01;
  // Period is only exact once no event, resync or write has disturbed the counter
  always_ff @(posedge i_mclk or negedge i_resetn)
    if (!i_resetn) quiet <= 7'h00;
    else if (i_sysref || i_rx_resync || (i_wb_cyc && i_wb_we)) quiet <= 7'h00;
    else if (quiet != 7'h7F) quiet <= quiet + 7'h01;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // ****************************************************************
  // Properties
  // ****************************************************************
  chk_ack_after_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not acknowledged in one cycle");
  chk_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("bus acknowledge longer than one cycle");
  chk_sync_on_bnd: assert property ($rose(o_rx_sync_n) && !ctl_sh[0] |-> o_lmfc_pulse)
    else $error("sync released off a multiframe boundary");
  chk_sync_after_cgs: assert property ($rose(o_rx_sync_n) |-> $past(i_rx_cgs_done))
    else $error("sync released without code group sync");
  chk_start_on_bnd: assert property ($rose(o_tx_running) |-> o_lmfc_pulse)
    else $error("transmit start off a multiframe boundary");
  chk_start_kind: assert property ($rose(o_tx_running) |-> $past(i_tx_sync_n) &&
    (ctl_sh[1] ? (o_tx_ila_start && !o_tx_data_start) : (o_tx_data_start && !o_tx_ila_start)))
    else $error("wrong transmit start pulse");
  chk_run_drops: assert property (o_tx_running && !i_tx_sync_n |-> ##[1:3] !o_tx_running)
    else $error("transmitter kept running after sync request");
  chk_release_bnd: assert property ($rose(o_rx_valid) |-> $past(o_lmfc_pulse))
    else $error("receive data released off a crossing");
  chk_data_word: assert property (o_rx_data == $past(i_rx_data))
    else $error("receive word not passed whole one cycle later");
  chk_lmfc_period: assert property (o_lmfc_pulse && quiet >= 7'h40 |-> gap == mflen_sh)
    else $error("multiframe crossing period wrong");
  cover property ($rose(o_rx_sync_n));
  cover property ($rose(o_tx_running) && o_tx_data_start);
  cover property ($rose(o_rx_valid));
endmodule
bind slmfc_top slmfc_top_asserts chk_u (.*);
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import slmfc_pkg::*;
  logic                     i_mclk, i_resetn, i_wb_cyc, i_wb_stb, i_wb_we, i_rx_resync, i_sysref;
  logic                     i_tx_sync_n, i_rx_cgs_done, i_rx_valid, o_wb_ack, o_rx_sync_n, o_rx_valid;
  logic                     o_tx_ila_start, o_tx_data_start, o_tx_running, o_lmfc_pulse;
  logic                     o_buffer_in_block_memory, ref_go, sync_rel, cgs_on, data_on;
  logic [SLMFC_ADR_W-1:0]   i_wb_adr;
  logic [SLMFC_SEL_W-1:0]   i_wb_sel;
  logic [SLMFC_DATA_W-1:0]  i_wb_dat, o_wb_dat, i_rx_data, o_rx_data, rd;
  logic [SLMFC_DEPTH_W-1:0] o_buffer_octet_depth;
  int                       bad_count, n_tests, cyc_n, l0, ph, tf, k;
  logic [7:0]               regs [4] = '{8'h00, 8'h04, 8'h08, 8'h24};
  logic [31:0]              rvals [4] = '{32'h0000_0200, 32'h0000_0007, 32'h0000_0020, 32'h0000_0000};
  int                       dl [3] = '{0, 9, 15};

  slmfc_top dut_u (.*);
  slmfc_conv_model model_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ref_go(ref_go), .i_sync_rel(sync_rel),
    .i_cgs(cgs_on), .i_data_on(data_on), .o_sysref(i_sysref), .o_tx_sync_n(i_tx_sync_n),
    .o_cgs_done(i_rx_cgs_done), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data));

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) cyc_n <= cyc_n + 1;

  // ****************************************************************
  // Access and check tasks
  // ****************************************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge i_mclk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= s;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 10);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    if (o_wb_ack !== 1'b1) begin
      bad_count++;
      end_sim;
    end
  endtask
  task fire(output int t);
    @(posedge i_mclk);
    ref_go <= 1'b1;
    t = cyc_n;
    @(posedge i_mclk);
    ref_go <= 1'b0;
  endtask
  // Phase of the crossing within a 32-cycle multiframe, once any realign has settled
  task phase(output int p);
    int n;
    repeat (40) @(posedge i_mclk);
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_lmfc_pulse !== 1'b1 && n < 80);
    p = cyc_n % 32;
    if (o_lmfc_pulse !== 1'b1) begin
      bad_count++;
      end_sim;
    end
  endtask
  task wait_link;
    int n;
    n = 0;
    while ((o_rx_sync_n !== 1'b1 || o_tx_running !== 1'b1) && n < 300) begin
      @(posedge i_mclk);
      n++;
    end
    chk("rx_sync_n", 32'(o_rx_sync_n), 32'h1);
    chk("tx_running", 32'(o_tx_running), 32'h1);
    if (n >= 300) end_sim;
  endtask
  task resync;
    @(posedge i_mclk);
    i_rx_resync <= 1'b1;
    sync_rel    <= 1'b0;
    cgs_on      <= 1'b0;
    @(posedge i_mclk);
    i_rx_resync <= 1'b0;
    repeat (4) @(posedge i_mclk);
    chk("rx_sync_n", 32'(o_rx_sync_n), 32'h0);
    chk("tx_running", 32'(o_tx_running), 32'h0);
    sync_rel <= 1'b1;
    cgs_on   <= 1'b1;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {i_resetn, i_wb_cyc, i_wb_stb, i_wb_we, i_rx_resync, ref_go, sync_rel, cgs_on, data_on} = 9'h000;
    i_wb_adr = 8'h00;
    i_wb_sel = 4'h0;
    i_wb_dat = 32'h0000_0000;
    {bad_count, n_tests, cyc_n} = {32'h0, 32'h0, 32'h0};
    repeat (12) @(posedge i_mclk);
    i_resetn <= 1'b1;
    for (k = 0; k < 4; k++) begin
      wb(1'b0, regs[k], 32'h0000_0000, 4'hF);
      chk("reg_reset", rd, rvals[k]);
    end
    chk("depth_out", 32'(o_buffer_octet_depth), 32'h0000_0020);
    wb(1'b1, 8'h08, 32'h0000_03FF, 4'h1);
    wb(1'b1, 8'h24, 32'hFFFF_FFFF, 4'hF);
    wb(1'b0, 8'h08, 32'h0000_0000, 4'hF);
    chk("depth_rd", rd, 32'h0000_00FF);
    chk("depth_out", 32'(o_buffer_octet_depth), 32'h0000_00FF);
    wb(1'b1, 8'h00, 32'h0000_0600, 4'hF);
    repeat (2) @(posedge i_mclk);
    chk("block_mem", 32'(o_buffer_in_block_memory), 32'h1);
    wb(1'b1, 8'h04, 32'h0000_001F, 4'h1);
    cgs_on   <= 1'b1;
    sync_rel <= 1'b1;
    data_on  <= 1'b1;
    repeat (50) @(posedge i_mclk);
    chk("rx_sync_n", 32'(o_rx_sync_n), 32'h0);
    chk("tx_running", 32'(o_tx_running), 32'h0);
    fire(tf);
    wait_link;
    phase(ph);
    l0 = (ph - tf % 32 + 32) % 32;
    k = ph;
    chk("rx_valid", 32'(o_rx_valid), 32'h1);
    repeat (7) @(posedge i_mclk);
    fire(tf);
    phase(ph);
    chk("phase_once", 32'(ph), 32'(k));
    wb(1'b0, 8'h0C, 32'h0000_0000, 4'hF);
    chk("phase_kept", rd, 32'h0000_010F);
    for (k = 0; k < 3; k++) begin
      wb(1'b1, 8'h00, 32'h0000_0201 | 32'(dl[k] << 4), 4'hF);
      repeat (k + 3) @(posedge i_mclk);
      fire(tf);
      phase(ph);
      chk("phase_delay", 32'(ph), 32'((tf + l0 + dl[k]) % 32));
    end
    wb(1'b1, 8'h00, 32'h0000_0200, 4'hF);
    resync;
    wait_link;
    wb(1'b1, 8'h00, 32'h0000_0202, 4'hF);
    resync;
    repeat (60) @(posedge i_mclk);
    chk("rx_sync_n", 32'(o_rx_sync_n), 32'h0);
    chk("tx_running", 32'(o_tx_running), 32'h0);
    fire(tf);
    wait_link;
    wb(1'b1, 8'h00, 32'h0000_0100, 4'hF);
    resync;
    wait_link;
    repeat (100) @(posedge i_mclk);
    end_sim;
  end
endmodule
`default_nettype wire
